// >>> fe_power_defs.svh
// constants for the front-end power-down controller
`ifndef FE_POWER_DEFS_SVH
`define FE_POWER_DEFS_SVH

// register indices on the serial register port
`define REG_MASK_LOW       7'h01
`define REG_MASK_HIGH      7'h02
`define REG_HD_SAVE        7'h03

// reset and strap default values, and the value read from an unmapped index
`define MASK_LOW_RST       8'h00
`define MASK_HIGH_RST      8'h7f
`define MASK_HIGH_ALL_OFF  8'hff
`define HD_SAVE_RST        8'hff
`define READ_UNMAPPED      8'h00

// block positions inside a power mask
`define BIT_CLK_SYN        3'h7
`define BIT_TX_CONV        3'h6
`define BIT_TX_DIG         3'h5
`define BIT_REF            3'h4
`define BIT_CML            3'h3
`define BIT_ADC            3'h2
`define BIT_PGA_BIAS       3'h1
`define BIT_RX_PGA         3'h0

// serial frame: read flag, 7-bit index, 8-bit data
`define SPI_LAST_HEAD_BIT  5'h07
`define SPI_LAST_BIT       5'h0f

// strap capture waits for the pin synchroniser to fill
`define STRAP_SETTLE       2'h2

// midscale flush length in word clocks
`define FLUSH_CYCLES       6'h21

// timing figures in ns, then in mclk cycles (each time divides exactly)
`define MCLK_NS            25
`define TX_PD_NS           100
`define TX_PU_NS           500
`define RX_PU_NS           2000
`define RX_PD_NS           500
`define TX_PD_CYC          (`TX_PD_NS / `MCLK_NS)
`define TX_PU_CYC          (`TX_PU_NS / `MCLK_NS)
`define RX_PU_CYC          (`RX_PU_NS / `MCLK_NS)
`define RX_PD_CYC          (`RX_PD_NS / `MCLK_NS)

`endif

// >>> fe_power_pkg.sv
// types for the front-end power-down controller
package fe_power_pkg;

  typedef struct packed {
    logic power_select;
    logic tx_burst;
    logic rx_burst;
    logic tx_silence;
    logic sclk;
    logic sel_n;
    logic sdio;
    logic mode;
    logic config_strap;
  } pins_t;

  typedef struct packed {
    logic [4:0] off_delay;
    logic       rx_via_tx;
    logic       tx_fast_en;
    logic       rx_fast_en;
  } hd_ctl_t;

  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_HEAD,
    SPI_DATA
  } spi_state_t;

endpackage : fe_power_pkg

// >>> pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage_a;

  // first stage feeds only the second
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_a <= '0;
      pin_out <= '0;
    end else begin
      stage_a <= pin_in;
      pin_out <= stage_a;
    end
  end

endmodule : pin_sync

`default_nettype wire

// >>> tx_off_delay.sv
// transmit-off delay counter and midscale flush window
`timescale 1ns/1ps
`default_nettype none
`include "fe_power_defs.svh"

module tx_off_delay (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       burst,
  input  wire logic [4:0] off_delay,
  output var  logic       tx_off,
  output var  logic       flush
);

  logic       burst_prev;
  logic       pending;
  logic [4:0] count;
  logic [5:0] flush_count;
  logic       fall_det;
  logic [5:0] elapsed;
  logic [4:0] delay_taken;

  assign fall_det = burst_prev && !burst; // see RQ22

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_prev <= 1'b0;
    end else begin
      burst_prev <= burst;
    end
  end

  // delayed off; a new burst cancels it at once
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= 1'b0;
      count   <= 5'h00;
      tx_off  <= 1'b0;
    end else if (burst) begin
      pending <= 1'b0;
      tx_off  <= 1'b0; // see RQ11
    end else if (fall_det) begin
      pending <= 1'b1;
      count   <= off_delay; // see RQ9
    end else if (pending && count == 5'h00) begin
      pending <= 1'b0;
      tx_off  <= 1'b1; // see RQ8
    end else if (pending) begin
      count <= count - 5'h01;
    end
  end

  // flush needs the word clock to keep running past the burst
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_count <= 6'h00;
    end else if (burst) begin
      flush_count <= 6'h00;
    end else if (fall_det) begin
      flush_count <= `FLUSH_CYCLES; // see RQ10
    end else if (flush_count != 6'h00) begin
      flush_count <= flush_count - 6'h01;
    end
  end

  assign flush = flush_count != 6'h00;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      elapsed     <= 6'h00;
      delay_taken <= 5'h00;
    end else if (fall_det) begin
      elapsed     <= 6'h01;
      delay_taken <= off_delay;
    end else if (elapsed != 6'h3f) begin
      elapsed <= elapsed + 6'h01;
    end
  end

  sequence burst_quiet;
    !burst [*8];
  endsequence

  off_delay_count_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ9
    $rose(tx_off) |-> elapsed == {1'b0, delay_taken} + 6'h02)
    else $error("transmit-off came at the wrong count");

  flush_window_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ10
    fall_det ##1 burst_quiet |-> flush)
    else $error("midscale flush ended too early");

endmodule : tx_off_delay

`default_nettype wire

// >>> front_end_power_down_control.sv
// front-end power-down controller: straps, register port, masks and burst control
`timescale 1ns/1ps
`default_nettype none
`include "fe_power_defs.svh"
// Summary of operation
// RQ1: power select low powers down every block set in the low mask.
// RQ2: power select high powers down every block set in the high mask.
// RQ3: power select change reaches the blocks with only minimal digital delay.
// RQ4: low mask resets to all on; high mask to all off except synthesizer.
// RQ5: mask bit 7 is synthesizer down to bit 0 receive gain amplifier.
// RQ6: half-duplex saving register acts only in half-duplex mode.
// RQ7: by default transmit burst pin drives fast switching; converter stays on.
// RQ8: transmit burst fall yields delayed off; transmit path down within 100 ns.
// RQ9: five-bit field sets transmit-off delay 0 to 31 word clocks, default 31.
// RQ10: filter flushed with midscale for 33 word clocks after the burst ends.
// RQ11: transmit burst rise powers transmit path up without delay, within 0.5 us.
// RQ12: bit 2 picks transmit or receive burst pin for receive-path power.
// RQ13: default: transmit fall powers receive up, rise powers it down.
// RQ14: receive pin selected: rise powers receive path up, fall powers down.
// RQ15: clearing bit 1 or bit 0 disables fast power-down of that path.
// RQ16: host loads complementary masks in full duplex, steers with power select.
// RQ17: full duplex: idle path down in 100 ns, paths up in 0.5 or 2 us.
// RQ18: full duplex silence pin low stops line amplifier and interpolation filter.
// RQ19: host feeds zero samples around filter power-down.
// RQ20: full duplex with config strap high: high mask all off, ref clock buffered.
// RQ21: mode strap low selects half duplex, high full duplex, sampled at reset.
// RQ22: burst edges and transmit-off delay are timed on the word clock.

module front_end_power_down_control
  import fe_power_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       power_select_pin,
  input  wire logic       tx_burst_pin,
  input  wire logic       rx_burst_pin,
  input  wire logic       tx_silence_pin,
  input  wire logic       mode_strap_pin,
  input  wire logic       config_strap_pin,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sel_n,
  input  wire logic       spi_sdio_in,
  output var  logic       spi_sdio_out,
  output var  logic       spi_sdio_oe_n,
  output var  logic [7:0] block_power_down,
  output var  logic       line_current_amp_off,
  output var  logic       interp_filter_disable,
  output var  logic       interp_flush_midscale,
  output var  logic       rx_clk_ref_buffer
);

  localparam int TX_PD_MAX = `TX_PD_CYC;
  localparam int TX_PU_MAX = `TX_PU_CYC;
  localparam int RX_PU_MAX = `RX_PU_CYC;
  localparam int RX_PD_MAX = `RX_PD_CYC;

  pins_t      raw;
  pins_t      s;
  logic       sclk_prev;
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic       full_duplex;
  logic [7:0] mask_low;
  logic [7:0] mask_high;
  logic [7:0] hd_save;
  hd_ctl_t    hd;
  spi_state_t spi_state;
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic       rd_cmd;
  logic [6:0] addr;
  logic [7:0] out_shift;
  logic       wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic       tx_off;
  logic       flush;
  logic       rx_off;
  logic       tx_fast;
  logic       rx_fast;
  logic [7:0] cur_mask;
  logic [7:0] next_power_down;
  logic       next_amp_off;
  logic       next_filter_disable;
  logic       sclk_rise;
  logic       sclk_fall;

  function automatic logic [7:0] reg_read(input logic [6:0] index, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic [7:0] hds);
    if (index == `REG_MASK_LOW) begin
      return lo;
    end else if (index == `REG_MASK_HIGH) begin
      return hi;
    end else if (index == `REG_HD_SAVE) begin
      return hds;
    end else begin
      return `READ_UNMAPPED;
    end
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign raw = '{power_select: power_select_pin, tx_burst: tx_burst_pin,
                 rx_burst: rx_burst_pin, tx_silence: tx_silence_pin, sclk: spi_sclk,
                 sel_n: spi_sel_n, sdio: spi_sdio_in, mode: mode_strap_pin,
                 config_strap: config_strap_pin};

  pin_sync #(
    .WIDTH ($bits(pins_t))
  ) u_pin_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin_in  (raw),
    .pin_out (s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release

  // straps are read through the synchroniser, so capture waits for it to fill
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt         <= 2'h0;
      strap_done        <= 1'b0;
      full_duplex       <= 1'b0;
      rx_clk_ref_buffer <= 1'b0;
    end else if (!strap_done && strap_cnt == `STRAP_SETTLE) begin
      strap_done        <= 1'b1;
      full_duplex       <= s.mode; // see RQ21
      rx_clk_ref_buffer <= s.mode && s.config_strap; // see RQ20
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial register port: read flag, 7-bit index, 8 data bits, msb first

  assign sclk_rise = s.sclk && !sclk_prev;
  assign sclk_fall = !s.sclk && sclk_prev;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= s.sclk;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_state <= SPI_IDLE;
      bit_cnt   <= 5'h00;
      shift_in  <= 8'h00;
      rd_cmd    <= 1'b0;
      addr      <= 7'h00;
      wr_stb    <= 1'b0;
      wr_addr   <= 7'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      case (spi_state)
        SPI_IDLE: begin
          bit_cnt <= 5'h00;
          if (!s.sel_n) begin
            spi_state <= SPI_HEAD;
          end
        end
        SPI_HEAD: begin
          if (s.sel_n) begin
            spi_state <= SPI_IDLE;
          end else if (sclk_rise) begin
            shift_in <= {shift_in[6:0], s.sdio};
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == `SPI_LAST_HEAD_BIT) begin
              rd_cmd    <= shift_in[6];
              addr      <= {shift_in[5:0], s.sdio};
              spi_state <= SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          if (s.sel_n) begin
            spi_state <= SPI_IDLE;
          end else if (sclk_rise) begin
            shift_in <= {shift_in[6:0], s.sdio};
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == `SPI_LAST_BIT) begin
              wr_stb    <= !rd_cmd;
              wr_addr   <= addr;
              wr_data   <= {shift_in[6:0], s.sdio};
              spi_state <= SPI_IDLE;
            end
          end
        end
        default: begin
          spi_state <= SPI_IDLE;
        end
      endcase
    end
  end

  // read data leaves on falling sclk so the host samples it on the rising one
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_shift     <= 8'h00;
      spi_sdio_out  <= 1'b0;
      spi_sdio_oe_n <= 1'b1;
    end else if (spi_state == SPI_HEAD && sclk_rise && bit_cnt == `SPI_LAST_HEAD_BIT) begin
      out_shift <= reg_read({shift_in[5:0], s.sdio}, mask_low, mask_high, hd_save);
    end else if (spi_state == SPI_DATA && rd_cmd && !s.sel_n) begin
      spi_sdio_oe_n <= 1'b0;
      if (sclk_fall) begin
        spi_sdio_out <= out_shift[7];
        out_shift    <= {out_shift[6:0], 1'b0};
      end
    end else begin
      spi_sdio_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power registers

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_low <= `MASK_LOW_RST; // see RQ4
    end else if (wr_stb && wr_addr == `REG_MASK_LOW) begin
      mask_low <= wr_data;
    end
  end

  // default of the high mask depends on the straps, so it is reloaded at capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_high <= `MASK_HIGH_RST; // see RQ4
    end else if (!strap_done && strap_cnt == `STRAP_SETTLE) begin
      mask_high <= (s.mode && s.config_strap) ? `MASK_HIGH_ALL_OFF : `MASK_HIGH_RST; // see RQ20
    end else if (wr_stb && wr_addr == `REG_MASK_HIGH) begin
      mask_high <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hd_save <= `HD_SAVE_RST; // see RQ9
    end else if (wr_stb && wr_addr == `REG_HD_SAVE) begin
      hd_save <= wr_data;
    end
  end

  assign hd = hd_ctl_t'(hd_save);

  ////////////////////////////////////////////////////////////////////////////////
  // burst control

  tx_off_delay u_tx_off_delay (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .burst     (s.tx_burst),
    .off_delay (hd.off_delay),
    .tx_off    (tx_off),
    .flush     (flush)
  );

  assign rx_off  = hd.rx_via_tx ? s.tx_burst : !s.rx_burst; // see RQ12 RQ13 RQ14
  assign tx_fast = !full_duplex && hd.tx_fast_en && tx_off; // see RQ6 RQ15
  assign rx_fast = !full_duplex && hd.rx_fast_en && rx_off; // see RQ6 RQ15

  ////////////////////////////////////////////////////////////////////////////////
  // power composition

  assign cur_mask = s.power_select ? mask_high : mask_low; // see RQ1 RQ2

  always_comb begin
    next_power_down     = cur_mask; // see RQ5
    next_amp_off        = cur_mask[`BIT_TX_CONV];
    next_filter_disable = 1'b0;
    if (full_duplex) begin
      next_amp_off        = cur_mask[`BIT_TX_CONV] || !s.tx_silence; // see RQ18
      next_filter_disable = !s.tx_silence; // see RQ18
    end else begin
      // converter stays on; tx fast drops only the line amplifier and tx digital, rx fast the ADC and rx gain amplifier
      if (tx_fast) begin
        next_power_down[`BIT_TX_DIG] = 1'b1; // see RQ7 RQ8
        next_amp_off                 = 1'b1; // see RQ7
      end
      if (rx_fast) begin
        next_power_down[`BIT_ADC]    = 1'b1; // see RQ13
        next_power_down[`BIT_RX_PGA] = 1'b1; // see RQ13
      end
    end
  end

  // a single register stage after the synchroniser: no clocked sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      block_power_down      <= `MASK_LOW_RST;
      line_current_amp_off  <= 1'b0;
      interp_filter_disable <= 1'b0;
      interp_flush_midscale <= 1'b0;
    end else begin
      block_power_down      <= next_power_down; // see RQ3 RQ17
      line_current_amp_off  <= next_amp_off;
      interp_filter_disable <= next_filter_disable;
      interp_flush_midscale <= !full_duplex && flush; // see RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  mask_low_applied_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ1
    full_duplex && !s.power_select |=> block_power_down == $past(mask_low))
    else $error("low mask not applied");

  mask_high_applied_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ2
    full_duplex && s.power_select |=> block_power_down == $past(mask_high))
    else $error("high mask not applied");

  select_latency_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ3
    $changed(s.power_select) && full_duplex && $stable(mask_low) && $stable(mask_high)
    |=> block_power_down == ($past(s.power_select) ? $past(mask_high) : $past(mask_low)))
    else $error("power select not applied in one cycle");

  default_mask_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ4
    $rose(strap_done) && !rx_clk_ref_buffer |-> mask_high == `MASK_HIGH_RST
    && mask_low == `MASK_LOW_RST)
    else $error("wrong mask defaults");

  all_off_default_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ20
    $rose(strap_done) && rx_clk_ref_buffer |-> mask_high == `MASK_HIGH_ALL_OFF && full_duplex)
    else $error("all-off default missing");

  hd_ignored_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ6
    full_duplex && s.tx_silence && !s.power_select && mask_low == `MASK_LOW_RST
    |=> block_power_down == `MASK_LOW_RST && !line_current_amp_off)
    else $error("half-duplex register acted in full duplex");

  tx_fast_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ8
    $rose(tx_off) && !full_duplex && hd.tx_fast_en
    |-> ##[1:TX_PD_MAX] block_power_down[`BIT_TX_DIG] && line_current_amp_off)
    else $error("transmit path not down in time");

  tx_fast_on_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ11
    $rose(s.tx_burst) && !full_duplex && !cur_mask[`BIT_TX_DIG] && !cur_mask[`BIT_TX_CONV]
    |-> ##[1:TX_PU_MAX] !block_power_down[`BIT_TX_DIG] && !line_current_amp_off)
    else $error("transmit path not up in time");

  rx_resume_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ13
    $fell(s.tx_burst) && !full_duplex && hd.rx_via_tx && !cur_mask[`BIT_ADC]
    |-> ##[1:RX_PU_MAX] !block_power_down[`BIT_ADC])
    else $error("receive path not up in time");

  rx_pin_down_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ14
    $fell(s.rx_burst) && !full_duplex && !hd.rx_via_tx && hd.rx_fast_en
    |-> ##[1:RX_PD_MAX] block_power_down[`BIT_ADC] && block_power_down[`BIT_RX_PGA])
    else $error("receive pin did not power down");

  silence_a: assert property (@(posedge mclk) disable iff (sys_rst) // see RQ18
    full_duplex && !s.tx_silence |=> line_current_amp_off && interp_filter_disable)
    else $error("silence pin ignored");

endmodule : front_end_power_down_control

`default_nettype wire

// >>> backend_model.sv
// back end model: burst pins, power select and the serial register port
`timescale 1ns/1ps
`default_nettype none

module backend_model (
  input  wire logic mclk,
  input  wire logic spi_sdio_out,
  input  wire logic spi_sdio_oe_n,
  output var  logic spi_sclk,
  output var  logic spi_sel_n,
  output var  logic spi_sdio_in,
  output var  logic tx_burst_pin,
  output var  logic rx_burst_pin,
  output var  logic power_select_pin,
  output var  logic tx_silence_pin
);
  ////////////////////////////////////////
  initial begin
    spi_sclk         = 1'b0;
    spi_sel_n        = 1'b1;
    spi_sdio_in      = 1'b1;
    tx_burst_pin     = 1'b0;
    rx_burst_pin     = 1'b0;
    power_select_pin = 1'b0;
    tx_silence_pin   = 1'b1;
  end

  // half periods of 6 mclk leave room for the 3-cycle sampling lag of the port
  task automatic frame(input logic rd, input logic [6:0] idx, input logic [7:0] wdat,
                       output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {rd, idx, wdat};
    rdat = 8'h00;
    spi_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdio_in = sh[i];
      repeat (6) @(negedge mclk);
      // an undriven line reads as the inverse, so a missing enable shows as a mismatch
      if (i < 8) rdat[i] = spi_sdio_oe_n ? ~spi_sdio_out : spi_sdio_out;
      spi_sclk = 1'b1;
      repeat (6) @(negedge mclk);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    spi_sel_n = 1'b1;
    // released line must not keep showing the last bit
    spi_sdio_in = ~sh[0];
    repeat (6) @(negedge mclk);
  endtask : frame
endmodule : backend_model

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the front-end power-down controller
`timescale 1ns/1ps
`default_nettype none
`include "fe_power_defs.svh"

module tb_top;
  logic       mclk = 1'b0;
  logic       sys_rst;
  logic       mode_strap_pin;
  logic       config_strap_pin;
  logic       power_select_pin;
  logic       tx_burst_pin;
  logic       rx_burst_pin;
  logic       tx_silence_pin;
  logic       spi_sclk;
  logic       spi_sel_n;
  logic       spi_sdio_in;
  logic       spi_sdio_out;
  logic       spi_sdio_oe_n;
  logic [7:0] block_power_down;
  logic       line_current_amp_off;
  logic       interp_filter_disable;
  logic       interp_flush_midscale;
  logic       rx_clk_ref_buffer;
  int         bad_count;
  int         cmp_count;
  int         cyc_count = 0;

  front_end_power_down_control i_front_end_power_down_control (
    .mclk(mclk), .sys_rst(sys_rst), .power_select_pin(power_select_pin),
    .tx_burst_pin(tx_burst_pin), .rx_burst_pin(rx_burst_pin), .tx_silence_pin(tx_silence_pin),
    .mode_strap_pin(mode_strap_pin), .config_strap_pin(config_strap_pin), .spi_sclk(spi_sclk),
    .spi_sel_n(spi_sel_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
    .spi_sdio_oe_n(spi_sdio_oe_n), .block_power_down(block_power_down),
    .line_current_amp_off(line_current_amp_off), .interp_filter_disable(interp_filter_disable),
    .interp_flush_midscale(interp_flush_midscale), .rx_clk_ref_buffer(rx_clk_ref_buffer));
  backend_model i_backend_model (.mclk(mclk), .spi_sdio_out(spi_sdio_out),
    .spi_sdio_oe_n(spi_sdio_oe_n),
    .spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n), .spi_sdio_in(spi_sdio_in),
    .tx_burst_pin(tx_burst_pin), .rx_burst_pin(rx_burst_pin),
    .power_select_pin(power_select_pin), .tx_silence_pin(tx_silence_pin));

  ////////////////////////////////////////
  always #12.5 mclk = ~mclk;

  // ceiling well above the ~2700 cycles the sequence needs
  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 40000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset(input logic mode, input logic cfg);
    sys_rst = 1'b1;
    mode_strap_pin = mode;
    config_strap_pin = cfg;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : do_reset

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] x;
    i_backend_model.frame(1'b0, idx, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [6:0] idx, input logic [7:0] e);
    logic [7:0] x;
    i_backend_model.frame(1'b1, idx, 8'h00, x);
    chk(what, e, x);
  endtask : rd_chk

  function automatic logic [7:0] rx_bits();
    return {6'h00, block_power_down[2], block_power_down[0]};
  endfunction : rx_bits

  task automatic tx_burst_run(input int dly);
    wr(`REG_HD_SAVE, {dly[4:0], 3'b111});
    i_backend_model.tx_burst_pin = 1'b1;
    repeat (23) @(negedge mclk);
    chk("tx_up", 8'h00, 8'(block_power_down[5]));
    chk("rx_down", 8'h03, rx_bits());
    chk("amp_on", 8'h00, 8'(line_current_amp_off));
    i_backend_model.tx_burst_pin = 1'b0;
    // off lands dly + 5 edges after the drop: two sync, detect, count, output register
    repeat (dly + 4) @(negedge mclk);
    chk("tx_held", 8'h00, 8'(block_power_down[5]));
    @(negedge mclk);
    chk("tx_off", 8'h01, 8'(block_power_down[5]));
    chk("amp_off", 8'h01, 8'(line_current_amp_off));
    chk("conv_on", 8'h00, 8'(block_power_down[6]));
    // flush shows from edge 4 to edge 36 after the drop, 33 edges
    repeat (31 - dly) @(negedge mclk);
    chk("flush_on", 8'h01, 8'(interp_flush_midscale));
    @(negedge mclk);
    chk("flush_end", 8'h00, 8'(interp_flush_midscale));
    repeat (35) @(negedge mclk);
    chk("rx_up", 8'h00, rx_bits());
  endtask : tx_burst_run

  ////////////////////////////////////////
  initial begin
    bad_count = 0;
    cmp_count = 0;
    do_reset(1'b0, 1'b0);
    rd_chk("mask_low", `REG_MASK_LOW, 8'h00);
    rd_chk("mask_high", `REG_MASK_HIGH, 8'h7f);
    rd_chk("hd_save", `REG_HD_SAVE, 8'hff);
    rd_chk("unmapped", 7'h05, 8'h00);
    tx_burst_run(31);
    tx_burst_run(4);
    // receive path handed to its own pin
    wr(`REG_HD_SAVE, 8'hfb);
    i_backend_model.rx_burst_pin = 1'b1;
    repeat (83) @(negedge mclk);
    chk("rxpin_up", 8'h00, rx_bits());
    i_backend_model.rx_burst_pin = 1'b0;
    repeat (23) @(negedge mclk);
    chk("rxpin_down", 8'h03, rx_bits());
    wr(`REG_HD_SAVE, 8'hf8);
    i_backend_model.tx_burst_pin = 1'b1;
    repeat (23) @(negedge mclk);
    i_backend_model.tx_burst_pin = 1'b0;
    repeat (50) @(negedge mclk);
    chk("tx_fast_off", 8'h00, 8'(block_power_down[5]));
    chk("rx_fast_off", 8'h00, rx_bits());
    // full duplex: saving register must have no effect
    do_reset(1'b1, 1'b0);
    i_backend_model.tx_burst_pin = 1'b1;
    repeat (23) @(negedge mclk);
    i_backend_model.tx_burst_pin = 1'b0;
    repeat (50) @(negedge mclk);
    chk("fd_ignore", 8'h00, block_power_down);
    chk("fd_flush", 8'h00, 8'(interp_flush_midscale));
    wr(`REG_MASK_LOW, 8'h60);
    wr(`REG_MASK_HIGH, 8'h05);
    repeat (6) @(negedge mclk);
    chk("sel_low", 8'h60, block_power_down);
    i_backend_model.power_select_pin = 1'b1;
    repeat (6) @(negedge mclk);
    chk("sel_high", 8'h05, block_power_down);
    i_backend_model.tx_silence_pin = 1'b0; // no samples are fed, so the filter holds zeros
    repeat (6) @(negedge mclk);
    chk("quiet_amp", 8'h01, 8'(line_current_amp_off));
    chk("quiet_filt", 8'h01, 8'(interp_filter_disable));
    i_backend_model.tx_silence_pin = 1'b1;
    do_reset(1'b1, 1'b1);
    rd_chk("mask_high_cfg", `REG_MASK_HIGH, 8'hff);
    chk("ref_buf", 8'h01, 8'(rx_clk_ref_buffer));
    chk("all_off", 8'hff, block_power_down);
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
